// >>> csq_pkg.sv
// Constants and types for the conversion timing sequencer
package csq_pkg;

    // ****************************************
    // Modulator timing
    // ****************************************
    localparam int unsigned         CSQ_MOD_DIV       = 16;
    localparam logic [3:0]          CSQ_MOD_LAST      = 4'(CSQ_MOD_DIV - 1);
    localparam logic [16:0]         CSQ_CFG_MODS      = 17'h0000E;
    localparam int unsigned         CSQ_RATES         = 14;
    localparam logic [3:0]          CSQ_RATE_MAX      = 4'hD;
    localparam logic [3:0]          CSQ_RATE_RESET    = 4'h0;

    // Oversampling ratio per rate code, index 0 = slowest
    localparam logic [13:0][16:0]   CSQ_OSR_TABLE     = {
        17'h00040, 17'h00080, 17'h00100, 17'h00140, 17'h00280, 17'h00500, 17'h00A00,
        17'h010A8, 17'h01400, 17'h03200, 17'h03C00, 17'h06400, 17'h0C800, 17'h19000
    };

    // First result in modulator periods per rate code
    localparam logic [13:0][16:0]   CSQ_FIRST_TABLE   = {
        17'h00076, 17'h000B6, 17'h00136, 17'h00176, 17'h002B6, 17'h00536, 17'h00A36,
        17'h010F7, 17'h01436, 17'h0388F, 17'h03C4F, 17'h06A8F, 17'h0CE8F, 17'h1968F
    };

    // ****************************************
    // Command port
    // ****************************************
    localparam logic [7:0]          CSQ_START_CMD     = 8'h08;
    localparam logic [2:0]          CSQ_WRITE_OP      = 3'h2;
    localparam logic [4:0]          CSQ_CFG_ADDR_LO   = 5'h03;
    localparam logic [4:0]          CSQ_CFG_ADDR_HI   = 5'h07;
    localparam logic [2:0]          CSQ_START_FALL    = 3'h6;
    localparam logic [4:0]          CSQ_START_BITS    = 5'h07;
    localparam logic [4:0]          CSQ_WRITE_LAST    = 5'h0F;
    localparam logic [4:0]          CSQ_BITS_SAT      = 5'h10;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        CSQ_IDLE     = 3'b000,
        CSQ_CFG      = 3'b001,
        CSQ_SAMPLE   = 3'b010,
        CSQ_OVERHEAD = 3'b011,
        CSQ_CONT     = 3'b100
    } csq_state_t;

    typedef struct packed {
        logic       busy;
        csq_state_t phase;
        logic [3:0] rate;
    } csq_status_t;

endpackage : csq_pkg

// >>> csq_sequencer.sv
// Conversion timing sequencer with command port and trigger pin
`timescale 1ns/1ps
module csq_sequencer
    import csq_pkg::*;
#(
    parameter logic [13:0][16:0] OSR_TABLE   = CSQ_OSR_TABLE,
    parameter logic [13:0][16:0] FIRST_TABLE = CSQ_FIRST_TABLE
) (
    // System clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    // Command port, link side
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        mosi_i,
    // Trigger pin
    input  wire logic        trigger_i,
    // Configuration
    input  wire logic [3:0]  rate_select_field_i,
    input  wire logic        continuous_mode_i,
    // Results
    output logic             result_strobe_o,
    output csq_status_t      status_o
);

    // ****************************************
    // Command port decode (link clock)
    // ****************************************
    logic [15:0] shift;
    logic [4:0]  bit_cnt;
    logic [2:0]  fall_cnt;
    logic        start_tgl;
    logic        cfg_tgl;

    wire  [7:0]  first_byte   = shift[14:7];
    wire  [2:0]  op_field     = first_byte[7:5];
    wire  [4:0]  addr_field   = first_byte[4:0];
    wire         write_frame  = (bit_cnt == CSQ_WRITE_LAST) &&
                                (op_field == CSQ_WRITE_OP);
    wire         cfg_addr_hit = (addr_field >= CSQ_CFG_ADDR_LO) &&
                                (addr_field <= CSQ_CFG_ADDR_HI);
    wire         start_hit    = (fall_cnt == CSQ_START_FALL) &&
                                (bit_cnt == CSQ_START_BITS) &&
                                (shift[6:0] == CSQ_START_CMD[7:1]);

    // ****************************************
    // Frame counters (link clock)
    // ****************************************
    // Frame state ends with chip select, so a stopped clock leaves nothing open
    always_ff @(posedge sclk_i or negedge reset_n_i or posedge cs_n_i) begin
        if (!reset_n_i) begin
            shift   <= 16'h0000;
            bit_cnt <= 5'h00;
        end else if (cs_n_i) begin
            shift   <= 16'h0000;
            bit_cnt <= 5'h00;
        end else begin
            shift   <= {shift[14:0], mosi_i};
            bit_cnt <= (bit_cnt == CSQ_BITS_SAT) ? bit_cnt : bit_cnt + 5'h01;
        end
    end

    always_ff @(negedge sclk_i or negedge reset_n_i or posedge cs_n_i) begin
        if (!reset_n_i) begin
            fall_cnt <= 3'h0;
        end else if (cs_n_i) begin
            fall_cnt <= 3'h0;
        end else if (fall_cnt != 3'h7) begin
            fall_cnt <= fall_cnt + 3'h1;
        end
    end

    // ****************************************
    // Event toggles (link clock)
    // ****************************************
    // Event toggles survive the frame end
    always_ff @(negedge sclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_tgl <= 1'b0;
        end else if (!cs_n_i && start_hit) begin
            start_tgl <= ~start_tgl;
        end
    end

    always_ff @(posedge sclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_tgl <= 1'b0;
        end else if (!cs_n_i && write_frame && cfg_addr_hit) begin
            cfg_tgl <= ~cfg_tgl;
        end
    end

    // ****************************************
    // Crossings into the system clock
    // ****************************************
    logic       start_evt;
    logic       cfg_evt;
    logic       trig_chg;
    logic       trig_level;

    // Toggles cross as levels, so a short link frame is never lost
    csq_sync3 start_sync_inst (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (start_tgl),
        .level_o   (),
        .change_o  (start_evt)
    );

    csq_sync3 cfg_sync_inst (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (cfg_tgl),
        .level_o   (),
        .change_o  (cfg_evt)
    );

    csq_sync3 trig_sync_inst (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (trigger_i),
        .level_o   (trig_level),
        .change_o  (trig_chg)
    );

    wire        trig_rise = trig_chg && trig_level;

    // ****************************************
    // Modulator period prescaler
    // ****************************************
    csq_state_t  state;
    csq_state_t  next_state;
    logic [3:0]  pre_cnt;
    logic [16:0] mod_cnt;
    logic [16:0] next_mod_cnt;
    logic [3:0]  rate;
    logic        next_strobe;

    // Config write only restarts a running conversion; idle single-shot stays idle
    wire         restart    = start_evt || trig_rise ||
                              (cfg_evt && (state != CSQ_IDLE));
    wire         mod_tick   = (pre_cnt == CSQ_MOD_LAST);
    wire         span_done  = mod_tick && (mod_cnt == 17'h00000);

    // ****************************************
    // Rate selection and span lengths
    // ****************************************
    // Undefined rate codes fall back to the fastest rate
    wire  [3:0]  rate_sel   = (rate_select_field_i > CSQ_RATE_MAX) ?
                              CSQ_RATE_MAX : rate_select_field_i;
    wire  [16:0] osr_mods   = OSR_TABLE[rate];
    wire  [16:0] first_mods = FIRST_TABLE[rate];
    wire  [16:0] ovh_mods   = first_mods - CSQ_CFG_MODS - osr_mods;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_cnt <= 4'h0;
        end else if (restart || mod_tick) begin
            pre_cnt <= 4'h0;
        end else begin
            pre_cnt <= pre_cnt + 4'h1;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // Counter loads sit one below the span, since zero ends it
    wire  [16:0] cfg_load   = CSQ_CFG_MODS - 17'h00001;
    wire  [16:0] osr_load   = osr_mods - 17'h00001;
    wire  [16:0] ovh_load   = ovh_mods - 17'h00001;
    wire  [16:0] count_down = (mod_tick && mod_cnt != 17'h00000) ? mod_cnt - 17'h00001 : mod_cnt;

    always_comb begin
        next_state   = state;
        next_mod_cnt = count_down;
        next_strobe  = 1'b0;
        if (restart) begin
            next_state   = CSQ_CFG;
            next_mod_cnt = cfg_load;
        end else begin
            unique case (state)
                CSQ_IDLE: begin
                    next_state = CSQ_IDLE;
                end
                CSQ_CFG: begin
                    if (span_done) begin
                        next_state   = CSQ_SAMPLE;
                        next_mod_cnt = osr_load;
                    end
                end
                CSQ_SAMPLE: begin
                    if (span_done) begin
                        next_state   = CSQ_OVERHEAD;
                        next_mod_cnt = ovh_load;
                    end
                end
                CSQ_OVERHEAD: begin
                    if (span_done) begin
                        next_strobe  = 1'b1;
                        next_state   = continuous_mode_i ? CSQ_CONT : CSQ_IDLE;
                        next_mod_cnt = osr_load;
                    end
                end
                CSQ_CONT: begin
                    if (span_done) begin
                        next_strobe  = 1'b1;
                        next_state   = continuous_mode_i ? CSQ_CONT : CSQ_IDLE;
                        next_mod_cnt = osr_load;
                    end
                end
                default: begin
                    next_state = CSQ_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Sequencer registers
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state           <= CSQ_IDLE;
            mod_cnt         <= 17'h00000;
            rate            <= CSQ_RATE_RESET;
            result_strobe_o <= 1'b0;
        end else begin
            state           <= next_state;
            mod_cnt         <= next_mod_cnt;
            rate            <= restart ? rate_sel : rate; // Rate held for the whole run
            result_strobe_o <= next_strobe;
        end
    end

    // ****************************************
    // Status output
    // ****************************************
    csq_status_t next_status;

    // Shows the coming phase so status and strobe change on one edge
    assign next_status = '{busy: (next_state != CSQ_IDLE), phase: next_state, rate: rate};

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_o <= '{busy: 1'b0, phase: CSQ_IDLE, rate: CSQ_RATE_RESET};
        end else begin
            status_o <= next_status;
        end
    end

endmodule : csq_sequencer

// ****************************************
// Three-stage synchroniser with agree check
// ****************************************
module csq_sync3
    import csq_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_n_i,
    // Level from another domain
    input  wire logic async_i,
    // Settled level and change pulse
    output logic      level_o,
    output logic      change_o
);

    logic [2:0] stages;
    logic       seen;

    // Change counts only once the last two stages agree
    wire        agree   = (stages[1] == stages[2]);
    wire        changed = agree && (stages[2] != seen);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stages <= 3'h0;
            seen   <= 1'b0;
        end else begin
            stages <= {stages[1:0], async_i};
            seen   <= changed ? stages[2] : seen;
        end
    end

    assign level_o  = stages[2];
    assign change_o = changed;

endmodule : csq_sync3

// >>> csq_props.sv
// Timing checker for the conversion timing sequencer
`timescale 1ns/1ps
module csq_props
    import csq_pkg::*;
#(
    parameter logic [13:0][16:0] OSR_TABLE   = CSQ_OSR_TABLE,
    parameter logic [13:0][16:0] FIRST_TABLE = CSQ_FIRST_TABLE
) (
    input wire logic        sys_clk_i,
    input wire logic        reset_n_i,
    input wire logic        trigger_i,
    input wire logic        continuous_mode_i,
    input wire logic        result_strobe_o,
    input wire csq_status_t status_o
);
    // Cycles spent in the phase seen last, and since the last strobe
    csq_state_t  prev;
    logic [20:0] cnt;
    logic [20:0] sc;
    wire  [3:0]  rt    = (status_o.rate > CSQ_RATE_MAX) ? CSQ_RATE_MAX : status_o.rate;
    wire  [20:0] osr16 = {OSR_TABLE[rt], 4'h0};
    wire  [20:0] ovh16 = {FIRST_TABLE[rt] - OSR_TABLE[rt] - CSQ_CFG_MODS, 4'h0};
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev <= CSQ_IDLE;
            cnt  <= 21'h0;
            sc   <= 21'h0;
        end else begin
            prev <= status_o.phase;
            cnt  <= (status_o.phase != prev) ? 21'h1 : cnt + 21'h1;
            sc   <= result_strobe_o ? 21'h1 : sc + 21'h1;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    a_strobe_pulse: assert property (result_strobe_o |=> !result_strobe_o)
        else $error("strobe longer than one cycle");
    a_cfg_length: assert property ((status_o.phase == CSQ_SAMPLE && prev == CSQ_CFG)
        |-> cnt == 21'h0E0) else $error("configuration delay length wrong");
    a_sample_length: assert property ((status_o.phase == CSQ_OVERHEAD && prev == CSQ_SAMPLE)
        |-> cnt == osr16) else $error("sampling length wrong");
    a_overhead_length: assert property ((result_strobe_o && prev == CSQ_OVERHEAD)
        |-> cnt == ovh16) else $error("overhead length wrong");
    a_cont_period: assert property ((result_strobe_o && prev == CSQ_CONT)
        |-> sc == osr16) else $error("continuous period wrong");
    a_strobe_source: assert property (result_strobe_o
        |-> (prev == CSQ_OVERHEAD || prev == CSQ_CONT)) else $error("strobe out of sequence");
    a_single_stop: assert property ((result_strobe_o && !$past(continuous_mode_i))
        |-> status_o.phase == CSQ_IDLE) else $error("single shot did not stop");
    a_trigger_start: assert property ($rose(trigger_i)
        |-> ##[3:5] status_o.phase == CSQ_CFG) else $error("trigger did not start");
endmodule : csq_props
bind csq_sequencer csq_props #(.OSR_TABLE(OSR_TABLE), .FIRST_TABLE(FIRST_TABLE)) csq_props_inst (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .trigger_i(trigger_i),
    .continuous_mode_i(continuous_mode_i), .result_strobe_o(result_strobe_o),
    .status_o(status_o));

// >>> csq_host.sv
// Host controller model driving the command port
`timescale 1ns/1ps
module csq_host (
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    // Link clock stands still between frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b1;
    end
    task automatic send(input logic [15:0] frame, input int nbits);
        cs_n_o = 1'b0;
        #2.3;
        for (int i = 15; i > 15 - nbits; i--) begin
            mosi_o = frame[i];
            #3 sclk_o = 1'b1;
            #3 sclk_o = 1'b0;
        end
        #3 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
    endtask : send
endmodule : csq_host

// >>> csq_sequencer_tb.sv
// Self-checking testbench for the conversion timing sequencer
`timescale 1ns/1ps
module csq_sequencer_tb;
    import csq_pkg::*;
    function automatic logic [13:0][16:0] mk_table(input logic [16:0] base);
        logic [13:0][16:0] t;
        for (int i = 0; i < 14; i++) t[i] = base + 17'(i);
        return t;
    endfunction : mk_table
    // Short tables keep the run small; OSR = 4 + code, first = 20 + code
    localparam logic [13:0][16:0] OSR_T   = mk_table(17'h04);
    localparam logic [13:0][16:0] FIRST_T = mk_table(17'h14);
    logic        sys_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        trigger_i = 1'b0;
    logic        continuous_mode_i = 1'b0;
    logic [3:0]  rate_select_field_i = 4'h0;
    wire logic   sclk_i;
    wire logic   cs_n_i;
    wire logic   mosi_i;
    logic        result_strobe_o;
    csq_status_t status_o;
    int          miscompares = 0;
    int          tests_run = 0;
    initial forever #50 sys_clk_i = ~sys_clk_i;
    csq_host csq_host_inst (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i));
    csq_sequencer #(.OSR_TABLE(OSR_T), .FIRST_TABLE(FIRST_T)) csq_sequencer_inst (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
        .mosi_i(mosi_i), .trigger_i(trigger_i), .rate_select_field_i(rate_select_field_i),
        .continuous_mode_i(continuous_mode_i), .result_strobe_o(result_strobe_o),
        .status_o(status_o));
    // *****
    // Helpers
    // *****
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check
    // Falling edges until a strobe shows, bounded
    task automatic wait_strobe(output logic [31:0] n);
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (result_strobe_o !== 1'b1 && n < 32'h7D0);
    endtask : wait_strobe
    task automatic check_phase(input csq_state_t ph);
        check("phase", {29'h0, ph}, {29'h0, status_o.phase});
    endtask : check_phase
    task automatic t_rates;
        logic [31:0] n;
        for (int r = 0; r < 14; r++) begin
            rate_select_field_i = 4'(r);
            trigger_i = 1'b1;
            wait_strobe(n);
            trigger_i = 1'b0;
            check("first result", 32'(16 * (20 + r) + 4), n);
            repeat (2) @(negedge sys_clk_i);
            check_phase(CSQ_IDLE);
            check("busy", 32'h0, {31'h0, status_o.busy});
            check("rate field", 32'(r), {28'h0, status_o.rate});
        end
        $display("test rates done");
    endtask : t_rates
    task automatic t_cont;
        logic [31:0] n;
        rate_select_field_i = 4'hD;
        continuous_mode_i = 1'b1;
        csq_host_inst.send({CSQ_START_CMD, 8'h00}, 8);
        wait_strobe(n);
        check("first strobe", 32'h1, {31'h0, result_strobe_o});
        check("command first result", 32'(16 * 33 + 4), n);
        check_phase(CSQ_CONT);
        check("busy", 32'h1, {31'h0, status_o.busy});
        wait_strobe(n);
        check("continuous period", 32'(16 * 17), n);
        continuous_mode_i = 1'b0;
        wait_strobe(n);
        check("last period", 32'(16 * 17), n);
        check_phase(CSQ_IDLE);
        $display("test continuous done");
    endtask : t_cont
    task automatic t_restart;
        logic [31:0] n;
        csq_host_inst.send({CSQ_WRITE_OP, CSQ_CFG_ADDR_LO, 8'hA5}, 16);
        repeat (20) @(negedge sys_clk_i);
        check_phase(CSQ_IDLE);
        rate_select_field_i = 4'hF;
        trigger_i = 1'b1;
        repeat (300) @(negedge sys_clk_i);
        trigger_i = 1'b0;
        check_phase(CSQ_SAMPLE);
        check("clamped rate", 32'hD, {28'h0, status_o.rate});
        csq_host_inst.send({CSQ_WRITE_OP, CSQ_CFG_ADDR_HI, 8'h5A}, 16);
        n = 0;
        while (status_o.phase !== CSQ_CFG && n < 32'h14) begin
            @(negedge sys_clk_i);
            n++;
        end
        wait_strobe(n);
        check("restarted result", 32'(16 * 33), n);
        $display("test restart done");
    endtask : t_restart
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (2) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        @(negedge sys_clk_i);
        t_rates;
        t_cont;
        t_restart;
        end_sim;
    end
    // About 8000 cycles expected; cut a hang well beyond that
    initial begin
        #3_000_000;
        miscompares++;
        end_sim;
    end
endmodule : csq_sequencer_tb
